// ### design/dag_direct_agu.sv
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// Operation
// - Immediates of 4, 8, 16, 32 bits used directly
// - Some accumulator loads move low word high first
// - Byte, word, long general registers selected explicitly
// - Special registers reachable as register operands
// - Stack pointer chosen by condition code S flag
// - Program counter never an explicit register operand
// - In-bank branch: operand to PC, bank kept
// - Physical branch: upper byte to bank, rest PC
// - Accumulator to byte register writes low eight bits
// - Abbreviated direct: operand, direct page, data bank or prefix-selected bank
// - 16-bit direct: operand low, data bank high
// - 16-bit direct ignores any bank prefix
module dag_direct_agu
   import dag_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Address output to the data bus
   output logic [23:0] agu_addr,
   output logic [23:0] agu_addr_hi,
   output logic agu_valid,
   output logic agu_branch
);

   // ---------------------------------------------------------------
   // Architectural registers
   // ---------------------------------------------------------------
   logic [31:0] acc;
   logic [15:0] pc;
   logic [7:0] program_bank_reg;
   logic [7:0] data_bank_reg;
   logic [7:0] additional_bank_reg;
   logic [7:0] direct_page_reg;
   logic [7:0] user_stack_bank_reg;
   logic [7:0] system_stack_bank_reg;
   logic [7:0] condition_code_reg;
   logic [4:0] register_bank_pointer;
   logic [2:0] interrupt_level_mask;
   logic [15:0] user_stack_pointer;
   logic [15:0] system_stack_pointer;
   logic [31:0] operand;
   logic [23:0] ea;
   logic [31:0] value;
   logic st_done;
   logic st_illegal;
   logic st_branch;

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   logic setup_ph;
   logic wr_done;
   logic [7:0] reg_off;
   logic gpr_hit;
   logic cmd_go;
   dag_cmd_s cmd;

   assign setup_ph = psel & ~penable;
   assign wr_done = psel & penable & pready & pwrite;
   assign reg_off = paddr[7:0];
   assign gpr_hit = (reg_off & GPR_WIN_MASK) == OFF_GPR;
   assign cmd_go = wr_done && reg_off == OFF_CMD;
   assign cmd = dag_cmd_s'(pwdata);

   // ---------------------------------------------------------------
   // Derived views
   // ---------------------------------------------------------------
   logic [15:0] psw_view;
   logic [15:0] stack_ptr;
   logic [7:0] stack_bank;

   assign psw_view = {interrupt_level_mask, register_bank_pointer,
                      condition_code_reg};
   assign stack_ptr = condition_code_reg[COND_S_BIT] ?
                      system_stack_pointer : user_stack_pointer;
   assign stack_bank = condition_code_reg[COND_S_BIT] ?
                       system_stack_bank_reg : user_stack_bank_reg;

   // ---------------------------------------------------------------
   // General register file
   // ---------------------------------------------------------------
   dag_cls_e gpr_rd_cls;
   logic [2:0] gpr_rd_idx;
   logic [31:0] gpr_rd_data;
   logic gpr_wr_en;
   dag_cls_e gpr_wr_cls;
   logic [2:0] gpr_wr_idx;
   logic [31:0] gpr_wr_data;
   logic cmd_gpr_wr;

   assign cmd_gpr_wr = cmd_go && cmd.mode == MODE_REG_WR &&
                       cmd.cls != CLS_SPEC;

   // Command and bus share one port; they never fall in one cycle
   always_comb
   begin
      if (cmd_go)
      begin
         gpr_rd_cls = cmd.cls;
         gpr_rd_idx = cmd.idx[2:0];
      end
      else
      begin
         gpr_rd_cls = CLS_WORD;
         gpr_rd_idx = reg_off[4:2];
      end
      if (cmd_gpr_wr)
      begin
         gpr_wr_en = 1'b1;
         gpr_wr_cls = cmd.cls;
         gpr_wr_idx = cmd.idx[2:0];
         gpr_wr_data = acc;
      end
      else
      begin
         gpr_wr_en = wr_done && gpr_hit;
         gpr_wr_cls = CLS_WORD;
         gpr_wr_idx = reg_off[4:2];
         gpr_wr_data = {16'h0000, pwdata[15:0]};
      end
   end

   dag_gpr_file u_gpr (
      .pclk(pclk),
      .presetn(presetn),
      .rd_cls(gpr_rd_cls),
      .rd_idx(gpr_rd_idx),
      .rd_data(gpr_rd_data),
      .wr_en(gpr_wr_en),
      .wr_cls(gpr_wr_cls),
      .wr_idx(gpr_wr_idx),
      .wr_data(gpr_wr_data)
   );

   // ---------------------------------------------------------------
   // Command evaluation
   // ---------------------------------------------------------------
   logic [31:0] imm_val;
   logic [31:0] spr_val;
   logic spr_ok;
   logic [31:0] next_value;
   logic [23:0] next_ea;
   logic next_illegal;
   logic next_branch;
   logic [7:0] dir_bank;

   always_comb
   begin
      case (cmd.width)
         W_IMM4: imm_val = {28'h000_0000, operand[3:0]};
         W_IMM8: imm_val = {24'h00_0000, operand[7:0]};
         W_IMM16: imm_val = {16'h0000, operand[15:0]};
         default: imm_val = operand;
      endcase
   end

   // Selector values 13..15 are holes, so no encoding reaches PC
   always_comb
   begin
      spr_ok = 1'b1;
      case (cmd.idx)
         SPR_ACC: spr_val = acc;
         SPR_ACC_LO: spr_val = {16'h0000, acc[15:0]};
         SPR_STK: spr_val = {16'h0000, stack_ptr};
         SPR_PBANK: spr_val = {24'h00_0000, program_bank_reg};
         SPR_DBANK: spr_val = {24'h00_0000, data_bank_reg};
         SPR_UBANK: spr_val = {24'h00_0000, user_stack_bank_reg};
         SPR_SBANK: spr_val = {24'h00_0000, system_stack_bank_reg};
         SPR_XBANK: spr_val = {24'h00_0000, additional_bank_reg};
         SPR_PAGE: spr_val = {24'h00_0000, direct_page_reg};
         SPR_PSW: spr_val = {16'h0000, psw_view};
         SPR_COND: spr_val = {24'h00_0000, condition_code_reg};
         SPR_BPTR: spr_val = {27'h000_0000, register_bank_pointer};
         SPR_ILVL: spr_val = {29'h0000_0000, interrupt_level_mask};
         default:
         begin
            spr_val = 32'h0000_0000;
            spr_ok = 1'b0;
         end
      endcase
   end

   always_comb
   begin
      case (cmd.prefix)
         PFX_PBANK: dir_bank = program_bank_reg;
         PFX_XBANK: dir_bank = additional_bank_reg;
         PFX_STK: dir_bank = stack_bank;
         default: dir_bank = data_bank_reg;
      endcase
   end

   always_comb
   begin
      next_value = 32'h0000_0000;
      next_ea = ea;
      next_illegal = 1'b0;
      next_branch = 1'b0;
      case (cmd.mode)
         MODE_IMM:
            next_value = imm_val;
         MODE_REG_RD:
         begin
            if (cmd.cls == CLS_SPEC)
            begin
               next_value = spr_val;
               next_illegal = ~spr_ok;
            end
            else
               next_value = gpr_rd_data;
         end
         MODE_REG_WR:
         begin
            next_value = acc;
            // Only general registers take the accumulator here
            next_illegal = cmd.cls == CLS_SPEC;
         end
         MODE_BR16:
         begin
            next_ea = {program_bank_reg, operand[15:0]};
            next_branch = 1'b1;
         end
         MODE_BR24:
         begin
            next_ea = operand[23:0];
            next_branch = 1'b1;
         end
         MODE_IO:
            next_ea = {16'h0000, operand[7:0]};
         MODE_DIR:
            next_ea = {dir_bank, direct_page_reg, operand[7:0]};
         MODE_ADDR16:
            next_ea = {data_bank_reg, operand[15:0]};
         default:
            next_illegal = 1'b1;
      endcase
   end

   // ---------------------------------------------------------------
   // Accumulator
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         acc <= RST_ACC;
      else if (cmd_go && cmd.mode == MODE_IMM && cmd.width == W_IMM32)
         acc <= imm_val;
      else if (cmd_go && cmd.mode == MODE_IMM)
      begin
         if (cmd.acc_xfer)
            acc[31:16] <= acc[15:0];
         acc[15:0] <= imm_val[15:0];
      end
      else if (wr_done && reg_off == OFF_ACC)
         acc <= pwdata;
   end

   // ---------------------------------------------------------------
   // Program counter and program bank
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pc <= RST_PC;
         program_bank_reg <= RST_BANK;
      end
      else if (cmd_go && cmd.mode == MODE_BR16)
         pc <= operand[15:0];
      else if (cmd_go && cmd.mode == MODE_BR24)
      begin
         program_bank_reg <= operand[23:16];
         pc <= operand[15:0];
      end
      else if (wr_done && reg_off == OFF_PC)
         pc <= pwdata[15:0];
      else if (wr_done && reg_off == OFF_BANKS)
         program_bank_reg <= pwdata[7:0];
   end

   // ---------------------------------------------------------------
   // Data banks, page, stacks and status
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         data_bank_reg <= RST_BANK;
         additional_bank_reg <= RST_BANK;
         direct_page_reg <= RST_BANK;
         user_stack_bank_reg <= RST_BANK;
         system_stack_bank_reg <= RST_BANK;
         condition_code_reg <= RST_COND;
         register_bank_pointer <= RST_BPTR;
         interrupt_level_mask <= RST_ILVL;
         user_stack_pointer <= RST_STK;
         system_stack_pointer <= RST_STK;
      end
      else if (wr_done)
      begin
         case (reg_off)
            OFF_BANKS:
            begin
               data_bank_reg <= pwdata[15:8];
               additional_bank_reg <= pwdata[23:16];
               direct_page_reg <= pwdata[31:24];
            end
            OFF_STK_BANKS:
            begin
               user_stack_bank_reg <= pwdata[7:0];
               system_stack_bank_reg <= pwdata[15:8];
            end
            OFF_PSW:
            begin
               condition_code_reg <= pwdata[7:0];
               register_bank_pointer <= pwdata[12:8];
               interrupt_level_mask <= pwdata[15:13];
            end
            OFF_USTK: user_stack_pointer <= pwdata[15:0];
            OFF_SSTK: system_stack_pointer <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Operand latch and results
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         operand <= 32'h0000_0000;
      else if (wr_done && reg_off == OFF_OPERAND)
         operand <= pwdata;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ea <= 24'h00_0000;
         value <= 32'h0000_0000;
         st_done <= 1'b0;
         st_illegal <= 1'b0;
         st_branch <= 1'b0;
      end
      else if (cmd_go)
      begin
         ea <= next_ea;
         value <= next_value;
         st_done <= 1'b1;
         st_illegal <= next_illegal;
         st_branch <= next_branch;
      end
   end

   // Second byte of a word sits one address up
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         agu_addr <= 24'h00_0000;
         agu_addr_hi <= 24'h00_0001;
         agu_valid <= 1'b0;
         agu_branch <= 1'b0;
      end
      else
      begin
         agu_valid <= cmd_go && !next_illegal &&
                      cmd.mode inside {MODE_BR16, MODE_BR24, MODE_IO,
                                       MODE_DIR, MODE_ADDR16};
         agu_branch <= cmd_go && next_branch;
         if (cmd_go)
         begin
            agu_addr <= next_ea;
            agu_addr_hi <= next_ea + 24'h00_0001;
         end
      end
   end

   // ---------------------------------------------------------------
   // APB response: one wait-free access phase, data fixed at setup
   // ---------------------------------------------------------------
   logic [31:0] next_rdata;
   logic next_err;

   always_comb
   begin
      next_err = 1'b0;
      next_rdata = 32'h0000_0000;
      if (gpr_hit)
         next_rdata = gpr_rd_data;
      else
      begin
         case (reg_off)
            OFF_CMD: next_rdata = 32'h0000_0000;
            OFF_OPERAND: next_rdata = operand;
            OFF_ACC: next_rdata = acc;
            OFF_PC: next_rdata = {16'h0000, pc};
            OFF_BANKS: next_rdata = {direct_page_reg, additional_bank_reg,
                                     data_bank_reg, program_bank_reg};
            OFF_STK_BANKS: next_rdata = {16'h0000, system_stack_bank_reg,
                                         user_stack_bank_reg};
            OFF_PSW: next_rdata = {16'h0000, psw_view};
            OFF_USTK: next_rdata = {16'h0000, user_stack_pointer};
            OFF_SSTK: next_rdata = {16'h0000, system_stack_pointer};
            OFF_EA: next_rdata = {8'h00, ea};
            OFF_VALUE: next_rdata = value;
            OFF_STATUS: next_rdata = {29'h0000_0000, st_branch,
                                      st_illegal, st_done};
            default: next_err = 1'b1;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= setup_ph;
         pslverr <= setup_ph & next_err;
         if (setup_ph && !pwrite)
            prdata <= next_rdata;
      end
   end

endmodule : dag_direct_agu

// ### design/dag_gpr_file.sv
`timescale 1ns/1ps
module dag_gpr_file
   import dag_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Read port
   input wire dag_cls_e rd_cls,
   input wire logic [2:0] rd_idx,
   output logic [31:0] rd_data,
   // Write port
   input wire logic wr_en,
   input wire dag_cls_e wr_cls,
   input wire logic [2:0] wr_idx,
   input wire logic [31:0] wr_data
);

   // ---------------------------------------------------------------
   // Byte storage: words at 2n, long words at 4n, bytes from 8 up
   // ---------------------------------------------------------------
   logic [7:0] mem [16];
   logic [3:0] rb;
   logic [3:0] wb;

   always_comb
   begin
      rb = 4'h0;
      rd_data = 32'h0000_0000;
      case (rd_cls)
         CLS_BYTE:
         begin
            rb = {1'b1, rd_idx};
            rd_data = {24'h00_0000, mem[rb]};
         end
         CLS_WORD:
         begin
            rb = {rd_idx, 1'b0};
            rd_data = {16'h0000, mem[rb + 4'h1], mem[rb]};
         end
         CLS_LONG:
         begin
            rb = {rd_idx[1:0], 2'b00};
            rd_data = {mem[rb + 4'h3], mem[rb + 4'h2],
                       mem[rb + 4'h1], mem[rb]};
         end
         default:
            rd_data = 32'h0000_0000;
      endcase
   end

   always_comb
   begin
      case (wr_cls)
         CLS_BYTE: wb = {1'b1, wr_idx};
         CLS_WORD: wb = {wr_idx, 1'b0};
         default: wb = {wr_idx[1:0], 2'b00};
      endcase
   end

   // Lower byte at lower address throughout
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < 16; i++)
            mem[i] <= 8'h00;
      end
      else if (wr_en)
      begin
         mem[wb] <= wr_data[7:0];
         if (wr_cls == CLS_WORD || wr_cls == CLS_LONG)
            mem[wb + 4'h1] <= wr_data[15:8];
         if (wr_cls == CLS_LONG)
         begin
            mem[wb + 4'h2] <= wr_data[23:16];
            mem[wb + 4'h3] <= wr_data[31:24];
         end
      end
   end

endmodule : dag_gpr_file

// ### include/dag_pkg.sv
package dag_pkg;

   // ---------------------------------------------------------------
   // Bus and register map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_CMD = 8'h00;
   localparam logic [7:0] OFF_OPERAND = 8'h04;
   localparam logic [7:0] OFF_ACC = 8'h08;
   localparam logic [7:0] OFF_PC = 8'h0C;
   localparam logic [7:0] OFF_BANKS = 8'h10;
   localparam logic [7:0] OFF_STK_BANKS = 8'h14;
   localparam logic [7:0] OFF_PSW = 8'h18;
   localparam logic [7:0] OFF_USTK = 8'h1C;
   localparam logic [7:0] OFF_SSTK = 8'h20;
   localparam logic [7:0] OFF_EA = 8'h24;
   localparam logic [7:0] OFF_VALUE = 8'h28;
   localparam logic [7:0] OFF_STATUS = 8'h2C;
   // Word general registers 0..7 at OFF_GPR + 4*n
   localparam logic [7:0] OFF_GPR = 8'h40;
   localparam logic [7:0] GPR_WIN_MASK = 8'hE3;

   // ---------------------------------------------------------------
   // Reset values and field positions
   // ---------------------------------------------------------------
   localparam logic [31:0] RST_ACC = 32'h0000_0000;
   localparam logic [15:0] RST_PC = 16'h0000;
   localparam logic [7:0] RST_BANK = 8'h00;
   localparam logic [7:0] RST_COND = 8'h00;
   localparam logic [4:0] RST_BPTR = 5'h00;
   localparam logic [2:0] RST_ILVL = 3'h0;
   localparam logic [15:0] RST_STK = 16'h0000;
   localparam int COND_S_BIT = 5;
   localparam int STAT_DONE_BIT = 0;
   localparam int STAT_ILLEGAL_BIT = 1;
   localparam int STAT_BRANCH_BIT = 2;

   // Special register selectors (class SPEC); 13..15 select nothing,
   // the program counter has no selector
   localparam logic [3:0] SPR_ACC = 4'h0;
   localparam logic [3:0] SPR_ACC_LO = 4'h1;
   localparam logic [3:0] SPR_STK = 4'h2;
   localparam logic [3:0] SPR_PBANK = 4'h3;
   localparam logic [3:0] SPR_DBANK = 4'h4;
   localparam logic [3:0] SPR_UBANK = 4'h5;
   localparam logic [3:0] SPR_SBANK = 4'h6;
   localparam logic [3:0] SPR_XBANK = 4'h7;
   localparam logic [3:0] SPR_PAGE = 4'h8;
   localparam logic [3:0] SPR_PSW = 4'h9;
   localparam logic [3:0] SPR_COND = 4'hA;
   localparam logic [3:0] SPR_BPTR = 4'hB;
   localparam logic [3:0] SPR_ILVL = 4'hC;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_IMM, MODE_REG_RD, MODE_REG_WR, MODE_BR16,
      MODE_BR24, MODE_IO, MODE_DIR, MODE_ADDR16
   } dag_mode_e;

   typedef enum logic [1:0] {W_IMM4, W_IMM8, W_IMM16, W_IMM32} dag_width_e;
   typedef enum logic [1:0] {CLS_BYTE, CLS_WORD, CLS_LONG, CLS_SPEC} dag_cls_e;
   typedef enum logic [1:0] {
      PFX_NONE, PFX_PBANK, PFX_XBANK, PFX_STK
   } dag_pfx_e;

   typedef struct packed {
      logic [9:0] rsv_hi;
      dag_pfx_e prefix;
      logic [2:0] rsv_c;
      logic acc_xfer;
      logic [3:0] idx;
      logic [1:0] rsv_b;
      dag_cls_e cls;
      logic [1:0] rsv_a;
      dag_width_e width;
      logic rsv_m;
      dag_mode_e mode;
   } dag_cmd_s;

endpackage : dag_pkg

// ### tb/dag_agu_checker.sv
`timescale 1ns/1ps
module dag_agu_checker
   import dag_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Address output
   input wire logic [23:0] agu_addr,
   input wire logic [23:0] agu_addr_hi,
   input wire logic agu_valid,
   input wire logic agu_branch
);
   logic [31:0] op_q;
   logic [31:0] bnk_q;
   logic wr_done;
   logic go;
   dag_cmd_s c;
   assign wr_done = psel && penable && pready && pwrite;
   assign go = wr_done && paddr == OFF_CMD;
   assign c = pwdata;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         op_q <= 32'h0000_0000;
      else if (wr_done && paddr == OFF_OPERAND)
         op_q <= pwdata;
   end

   // Shadow of the bank word, including the bank load of a long branch
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         bnk_q <= 32'h0000_0000;
      else if (wr_done && paddr == OFF_BANKS)
         bnk_q <= pwdata;
      else if (go && c.mode == MODE_BR24)
         bnk_q[7:0] <= op_q[23:16];
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_RDY: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   AST_RDY_ONE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_ERR: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   AST_HI: assert property (agu_addr_hi == agu_addr + 24'h00_0001)
      else $error("high byte address not next address");
   AST_PULSE: assert property (agu_valid |=> !agu_valid)
      else $error("agu_valid not a pulse");
   AST_BR16: assert property (go && c.mode == MODE_BR16 |=>
      agu_branch && agu_addr == {bnk_q[7:0], op_q[15:0]})
      else $error("in-bank branch target wrong");
   AST_BR24: assert property (go && c.mode == MODE_BR24 |=>
      agu_branch && agu_addr == op_q[23:0])
      else $error("physical branch target wrong");
   AST_DIR: assert property (go && c.mode == MODE_DIR &&
      c.prefix == PFX_NONE |=> agu_valid && !agu_branch &&
      agu_addr == {bnk_q[15:8], bnk_q[31:24], op_q[7:0]})
      else $error("abbreviated direct address wrong");
   AST_A16: assert property (go && c.mode == MODE_ADDR16 |=>
      agu_valid && !agu_branch && agu_addr == {bnk_q[15:8], op_q[15:0]})
      else $error("direct 16-bit address wrong");
   AST_IO: assert property (go && c.mode == MODE_IO |=>
      agu_valid && !agu_branch && agu_addr == {16'h0000, op_q[7:0]})
      else $error("io direct address wrong");
endmodule : dag_agu_checker

bind dag_direct_agu dag_agu_checker u_chk (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .agu_addr, .agu_addr_hi, .agu_valid, .agu_branch);

// ### tb/dag_apb_master.sv
`timescale 1ns/1ps
module dag_apb_master
   import dag_pkg::*;
(
   // Clock
   input wire logic pclk,
   // APB request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [ADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   // APB answer
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end

   // Entered just after a rising edge; ends one idle edge after pready
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released data must not look like a held value
      pwdata <= ~d;
      // Idle edge: a following call never drives psel twice in one step
      @(posedge pclk);
   endtask : xfer
endmodule : dag_apb_master

// ### tb/direct_addressing_agu_bench.sv
`timescale 1ns/1ps
module direct_addressing_agu_bench;
   import dag_pkg::*;
   typedef struct {
      logic [31:0] cmd;
      logic [31:0] op;
      logic [31:0] bnk;
      logic [23:0] ea;
   } dag_row_s;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic agu_valid, agu_branch;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [23:0] agu_addr, agu_addr_hi;
   int failures;
   int compares;
   logic [31:0] exp_ea;
   dag_row_s rows [7];

   dag_direct_agu u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .agu_addr,
      .agu_addr_hi, .agu_valid, .agu_branch);
   dag_apb_master u_mst (.pclk, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr);

   initial
      pclk = 1'b0;
   always #2 pclk = ~pclk;

   task automatic chk(string n, logic [31:0] exp, logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", n, exp, got);
         failures++;
      end
   endtask : chk

   task automatic wr(logic [7:0] a, logic [31:0] d);
      u_mst.xfer(1'b1, a, d, rdv, err);
   endtask : wr

   task automatic rd_chk(string n, logic [7:0] a, logic [31:0] exp);
      u_mst.xfer(1'b0, a, 32'h0000_0000, rdv, err);
      chk(n, exp, rdv);
   endtask : rd_chk

   task automatic end_sim;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   // Watchdog: the whole run needs about one microsecond
   initial
   begin
      #20000;
      failures++;
      end_sim();
   end

   initial
   begin
      failures = 0;
      compares = 0;
      presetn = 1'b0;
      rows = '{
         '{32'h0000_0003, 32'h0000_3B20, 32'h0000_004F, 24'h4F3B20},
         '{32'h0000_0004, 32'h0033_3B20, 32'h0000_004F, 24'h333B20},
         '{32'h0000_0005, 32'h0000_ABC0, 32'hFFFF_FFFF, 24'h0000C0},
         '{32'h0000_0006, 32'h0000_0020, 32'h6600_7700, 24'h776620},
         '{32'h0010_0007, 32'h0000_2222, 32'h0000_5500, 24'h552222},
         '{32'h0030_0007, 32'h0000_FFFF, 32'hAA11_BBCC, 24'hBBFFFF},
         '{32'h0020_0006, 32'h0000_0020, 32'h6611_7700, 24'h116620}};
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("addr_hi", 32'h0000_0001, {8'h00, agu_addr_hi});
      rd_chk("acc", OFF_ACC, RST_ACC);
      $display("test reset done");
      foreach (rows[i])
      begin
         exp_ea = {8'h00, rows[i].ea};
         wr(OFF_BANKS, rows[i].bnk);
         wr(OFF_OPERAND, rows[i].op);
         wr(OFF_CMD, rows[i].cmd);
         rd_chk("ea", OFF_EA, exp_ea);
         chk("agu_addr", exp_ea, {8'h00, agu_addr});
      end
      $display("test address rows done");
      // Long branch then in-bank branch, back to back
      wr(OFF_BANKS, 32'h0000_004F);
      wr(OFF_OPERAND, 32'h0033_3B20);
      wr(OFF_CMD, 32'h0000_0004);
      rd_chk("banks", OFF_BANKS, 32'h0000_0033);
      wr(OFF_OPERAND, 32'h0000_1234);
      wr(OFF_CMD, 32'h0000_0003);
      rd_chk("ea", OFF_EA, 32'h0033_1234);
      $display("test branch chain done");
      wr(OFF_OPERAND, 32'hFEDC_BA98);
      for (int w = 0; w < 4; w++)
      begin
         wr(OFF_CMD, {26'h0, w[1:0], 4'h0});
         rd_chk("imm", OFF_VALUE,
            32'hFEDC_BA98 & ~(32'hFFFF_FFFF << (4 << w)));
      end
      wr(OFF_ACC, 32'h2233_4455);
      wr(OFF_OPERAND, 32'h0000_1212);
      wr(OFF_CMD, 32'h0001_0020);
      rd_chk("acc", OFF_ACC, 32'h4455_1212);
      $display("test immediate done");
      wr(OFF_ACC, 32'h0716_2534);
      wr(OFF_CMD, 32'h0000_0002);
      rd_chk("r0", 8'h50, 32'h0000_0034);
      wr(OFF_CMD, 32'h0000_3102);
      rd_chk("rw3", 8'h4C, 32'h0000_2534);
      wr(OFF_CMD, 32'h0000_0001);
      rd_chk("r0_value", OFF_VALUE, 32'h0000_0034);
      wr(OFF_CMD, 32'h0000_1201);
      rd_chk("rl1_value", OFF_VALUE, 32'h2534_0000);
      wr(OFF_USTK, 32'h0000_1111);
      wr(OFF_SSTK, 32'h0000_2222);
      for (int s = 0; s < 2; s++)
      begin
         wr(OFF_PSW, s[0] ? 32'h0000_0020 : 32'h0000_0000);
         wr(OFF_CMD, 32'h0000_2301);
         rd_chk("stk", OFF_VALUE, s[0] ? 32'h2222 : 32'h1111);
      end
      wr(OFF_CMD, 32'h0000_D301);
      u_mst.xfer(1'b0, OFF_STATUS, 32'h0000_0000, rdv, err);
      chk("illegal", 32'h0000_0001, {31'h0, rdv[STAT_ILLEGAL_BIT]});
      u_mst.xfer(1'b0, 8'h30, 32'h0000_0000, rdv, err);
      chk("pslverr", 32'h0000_0001, {31'h0, err});
      $display("test registers done");
      // Reset again in mid-run: the accumulator and agu_addr_hi built up above must return to reset values
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("addr_hi", 32'h0000_0001, {8'h00, agu_addr_hi});
      rd_chk("acc", OFF_ACC, RST_ACC);
      $display("test second reset done");
      end_sim();
   end
endmodule : direct_addressing_agu_bench
